// *** core/mgr_consts.svh ***
`ifndef MGR_CONSTS_SVH
`define MGR_CONSTS_SVH
`define MGR_AW 11
`define MGR_LW 12
`define MGR_MAXLEN 12'h0800
`define MGR_ERR_W 6
`define MGR_ERR_PHY 0
`endif

// *** core/mgr_pkg.sv ***
// Purpose: types shared by the frame port and its frame memory.
// Assumes: widths come from mgr_consts.svh.
// Notes: one state struct per direction in each clock domain, plus one for the falling-edge captures.
`include "mgr_consts.svh"
package mgr_pkg;
  typedef struct packed {
    logic [7:0] byte_data;
    logic start_of_packet;
    logic client_transmit_end_of_packet;
    logic client_transmit_error;
  } mgr_tx_beat_t;
  typedef struct packed {
    logic [7:0] byte_data;
    logic start_of_packet;
    logic end_of_packet;
    logic [`MGR_ERR_W-1:0] rx_error;
  } mgr_rx_beat_t;
  typedef enum logic {CTX_FILL = 1'b0, CTX_WAIT = 1'b1} mgr_ctx_st_t;
  typedef enum logic [1:0] {LTX_IDLE = 2'b00, LTX_LOAD = 2'b01,
    LTX_SEND = 2'b10} mgr_ltx_st_t;
  typedef enum logic [1:0] {LRX_IDLE = 2'b00, LRX_RECV = 2'b01,
    LRX_DROP = 2'b10} mgr_lrx_st_t;
  typedef enum logic [1:0] {CRX_IDLE = 2'b00, CRX_ADDR = 2'b01,
    CRX_READ = 2'b10, CRX_SHOW = 2'b11} mgr_crx_st_t;
  typedef struct packed {
    mgr_ctx_st_t st;
    logic [`MGR_LW-1:0] ptr;
    logic [`MGR_LW-1:0] len;
    logic err;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
  } mgr_ctx_t;
  typedef struct packed {
    mgr_ltx_st_t st;
    logic [`MGR_AW-1:0] rd_addr;
    logic [`MGR_LW-1:0] cnt;
    logic [`MGR_LW-1:0] len;
    logic err;
    logic en;
    logic tx_err;
    logic [7:0] tx_byte;
    logic ack_tgl;
    logic req_s1;
    logic req_s2;
    logic mode_s1;
    logic mode_s2;
  } mgr_ltx_t;
  typedef struct packed {
    mgr_lrx_st_t st;
    logic [`MGR_LW-1:0] ptr;
    logic [`MGR_LW-1:0] len;
    logic err;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] s_byte;
    logic s_dv;
    logic s_er;
    logic [3:0] r_nib;
    logic r_ctl;
  } mgr_lrx_t;
  typedef struct packed {
    mgr_crx_st_t st;
    logic [`MGR_LW-1:0] addr;
    logic [`MGR_LW-1:0] len;
    logic err;
    logic ack_tgl;
    logic req_s1;
    logic req_s2;
    logic valid;
    mgr_rx_beat_t beat;
  } mgr_crx_t;
  typedef struct packed {
    logic [3:0] tx_nib;
    logic tx_ctl;
    logic [3:0] rx_nib;
    logic rx_ctl;
  } mgr_fall_t;
endpackage

// *** core/mgr_frame_ram.sv ***
// Purpose: one-frame byte store, written on one clock, read on another.
// Assumes: the writer never touches a frame the reader is still using.
// Notes: read data is registered, so it lags the address by one edge.
`timescale 1ns/1ps
`include "mgr_consts.svh"
module mgr_frame_ram
  import mgr_pkg::*;
(
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [`MGR_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_clk,
  input wire logic [`MGR_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<`MGR_AW)-1];

  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// *** core/mgr_frame_port.sv ***
// Purpose: GMII/RGMII frame port of a tri-speed Ethernet MAC.
// Assumes: phy_clk is the link clock for both directions.
// Notes: each direction buffers one whole frame between domains.
// Summary of operation
// R01: GMII transmit byte launches on the rising transmit clock edge.
// R02: Transmit enable high from first to last byte, low between frames.
// R03: Client frame with error at end of packet gets transmit error.
// R04: GMII receive inputs sampled on rising edge; PHY frames valid.
// R05: PHY raises receive error at least one cycle within a bad frame.
// R06: Frames received with PHY error leave with error bit zero set.
// R07: RGMII nibbles on both edges; control high through the frame.
// R08: RGMII transmit error shown on control at the falling edge.
// R09: RGMII receive sampled on both edges; control high through frame.
// R10: Low nibble rising, high nibble falling; control valid then error.
`timescale 1ns/1ps
`include "mgr_consts.svh"
module mgr_frame_port
  import mgr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic phy_clk,
  input wire logic rgmii_mode,
  input wire logic client_tx_valid,
  output logic client_tx_ready,
  input wire mgr_tx_beat_t client_tx_beat,
  output logic client_rx_valid,
  input wire logic client_rx_ready,
  output mgr_rx_beat_t client_rx_beat,
  output logic [7:0] gmii_transmit_byte,
  output logic gmii_transmit_enable,
  output logic gmii_transmit_error,
  input wire logic [7:0] gmii_receive_byte,
  input wire logic gmii_receive_valid,
  input wire logic gmii_receive_error,
  output logic [3:0] rgmii_transmit_nibble,
  output logic rgmii_transmit_control,
  input wire logic [3:0] rgmii_receive_nibble,
  input wire logic rgmii_receive_control
);
  mgr_ctx_t ctx_r, ctx_nxt;
  mgr_ltx_t lt_r, lt_nxt;
  mgr_lrx_t lr_r, lr_nxt;
  mgr_crx_t cr_r, cr_nxt;
  mgr_fall_t fall_r;
  logic [1:0] lrst_r;
  logic link_rst;
  logic tx_we, rx_we;
  logic [`MGR_AW-1:0] rx_wa;
  logic [7:0] tx_rd, rx_rd;
  logic [`MGR_LW-1:0] en_run_r;

  function automatic logic mgr_pending(input logic req, input logic ack);
    return req ^ ack;
  endfunction

  // The link logic leaves reset only once phy_clk is running.
  always_ff @(posedge phy_clk or posedge reset) begin
    if (reset) begin
      lrst_r <= 2'h3;
    end else begin
      lrst_r <= {lrst_r[0], 1'b0};
    end
  end
  assign link_rst = lrst_r[1];

  mgr_frame_ram u_tx_ram (
    .wr_clk(clk),
    .wr_en(tx_we),
    .wr_addr(ctx_r.ptr[`MGR_AW-1:0]),
    .wr_data(client_tx_beat.byte_data),
    .rd_clk(phy_clk),
    .rd_addr(lt_r.rd_addr),
    .rd_data(tx_rd)
  );

  mgr_frame_ram u_rx_ram (
    .wr_clk(phy_clk),
    .wr_en(rx_we),
    .wr_addr(rx_wa),
    .wr_data(lr_r.s_byte),
    .rd_clk(clk),
    .rd_addr(cr_r.addr[`MGR_AW-1:0]),
    .rd_data(rx_rd)
  );

  // Client transmit side: the whole frame is stored before it is offered
  // to the link, so transmit enable never gaps inside a frame.
  assign client_tx_ready = (ctx_r.st == CTX_FILL);
  assign tx_we = client_tx_valid && client_tx_ready &&
    (ctx_r.ptr != `MGR_MAXLEN);

  always_comb begin
    ctx_nxt = ctx_r;
    ctx_nxt.ack_s1 = lt_r.ack_tgl;
    ctx_nxt.ack_s2 = ctx_r.ack_s1;
    unique case (ctx_r.st)
      CTX_FILL: begin
        if (client_tx_valid) begin
          if (ctx_r.ptr != `MGR_MAXLEN) begin
            ctx_nxt.ptr = ctx_r.ptr + 1'b1;
          end else begin
            ctx_nxt.err = 1'b1;
          end
          if (client_tx_beat.client_transmit_end_of_packet) begin
            // R03: latch client error
            ctx_nxt.err = ctx_nxt.err | client_tx_beat.client_transmit_error;
            ctx_nxt.len = ctx_nxt.ptr;
            ctx_nxt.ptr = '0;
            ctx_nxt.req_tgl = ~ctx_r.req_tgl;
            ctx_nxt.st = CTX_WAIT;
          end
        end
      end
      CTX_WAIT: begin
        if (!mgr_pending(ctx_r.req_tgl, ctx_r.ack_s2)) begin
          ctx_nxt.err = 1'b0;
          ctx_nxt.st = CTX_FILL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctx_r <= '0;
    end else begin
      ctx_r <= ctx_nxt;
    end
  end

  // Link transmit side. Length and error are stable while the request
  // toggle is pending, so they are read across the domain directly.
  always_comb begin
    lt_nxt = lt_r;
    lt_nxt.req_s1 = ctx_r.req_tgl;
    lt_nxt.req_s2 = lt_r.req_s1;
    lt_nxt.mode_s1 = rgmii_mode;
    lt_nxt.mode_s2 = lt_r.mode_s1;
    // R02: enable low between frames
    lt_nxt.en = 1'b0;
    lt_nxt.tx_err = 1'b0;
    lt_nxt.tx_byte = 8'h00;
    unique case (lt_r.st)
      LTX_IDLE: begin
        if (mgr_pending(lt_r.req_s2, lt_r.ack_tgl)) begin
          lt_nxt.len = ctx_r.len;
          lt_nxt.err = ctx_r.err;
          lt_nxt.rd_addr = '0;
          lt_nxt.cnt = '0;
          lt_nxt.st = LTX_LOAD;
        end
      end
      LTX_LOAD: begin
        lt_nxt.rd_addr = lt_r.rd_addr + 1'b1;
        lt_nxt.st = LTX_SEND;
      end
      LTX_SEND: begin
        // R02: enable held through frame
        lt_nxt.en = 1'b1;
        lt_nxt.tx_byte = tx_rd;
        lt_nxt.rd_addr = lt_r.rd_addr + 1'b1;
        lt_nxt.cnt = lt_r.cnt + 1'b1;
        if (lt_r.cnt == lt_r.len - 1'b1) begin
          // R03: error on last byte
          lt_nxt.tx_err = lt_r.err;
          lt_nxt.ack_tgl = ~lt_r.ack_tgl;
          lt_nxt.st = LTX_IDLE;
        end
      end
      default: lt_nxt.st = LTX_IDLE;
    endcase
  end

  // R01: launch on rising edge
  always_ff @(posedge phy_clk or posedge link_rst) begin
    if (link_rst) begin
      lt_r <= '0;
    end else begin
      lt_r <= lt_nxt;
    end
  end

  assign gmii_transmit_byte = lt_r.tx_byte;
  assign gmii_transmit_enable = lt_r.en;
  assign gmii_transmit_error = lt_r.tx_err;

  // R07: second half of each byte
  // R08: error combined at falling edge
  // R09: receive falling-edge capture
  always_ff @(negedge phy_clk or posedge link_rst) begin
    if (link_rst) begin
      fall_r <= '0;
    end else begin
      fall_r <= '{tx_nib: lt_r.tx_byte[7:4], tx_ctl: lt_r.en ^ lt_r.tx_err,
        rx_nib: rgmii_receive_nibble, rx_ctl: rgmii_receive_control};
    end
  end

  // R10: low nibble and valid while the clock is high.
  // The clock selects the half, as an output DDR cell would.
  assign rgmii_transmit_nibble = phy_clk ? lt_r.tx_byte[3:0] : fall_r.tx_nib;
  assign rgmii_transmit_control = phy_clk ? lt_r.en : fall_r.tx_ctl;

  // Link receive side. A frame that starts while the previous one is
  // still unread is dropped whole rather than corrupting the store.
  always_comb begin
    lr_nxt = lr_r;
    rx_we = 1'b0;
    rx_wa = lr_r.ptr[`MGR_AW-1:0];
    lr_nxt.ack_s1 = cr_r.ack_tgl;
    lr_nxt.ack_s2 = lr_r.ack_s1;
    lr_nxt.r_nib = rgmii_receive_nibble;
    lr_nxt.r_ctl = rgmii_receive_control;
    if (lt_r.mode_s2) begin
      // R10: pair rising and falling halves
      lr_nxt.s_byte = {fall_r.rx_nib, lr_r.r_nib};
      lr_nxt.s_dv = lr_r.r_ctl;
      lr_nxt.s_er = lr_r.r_ctl ^ fall_r.rx_ctl;
    end else begin
      // R04: rising-edge GMII sample
      lr_nxt.s_byte = gmii_receive_byte;
      lr_nxt.s_dv = gmii_receive_valid;
      lr_nxt.s_er = gmii_receive_error;
    end
    unique case (lr_r.st)
      LRX_IDLE: begin
        if (lr_r.s_dv) begin
          if (mgr_pending(lr_r.req_tgl, lr_r.ack_s2)) begin
            lr_nxt.st = LRX_DROP;
          end else begin
            rx_we = 1'b1;
            rx_wa = '0;
            lr_nxt.ptr = `MGR_LW'(1);
            lr_nxt.err = lr_r.s_er;
            lr_nxt.st = LRX_RECV;
          end
        end
      end
      LRX_RECV: begin
        if (lr_r.s_dv) begin
          rx_we = (lr_r.ptr != `MGR_MAXLEN);
          if (rx_we) begin
            lr_nxt.ptr = lr_r.ptr + 1'b1;
          end
          // R05: error seen any cycle
          // R06: collect PHY error
          lr_nxt.err = lr_r.err | lr_r.s_er | !rx_we;
        end else begin
          lr_nxt.len = lr_r.ptr;
          lr_nxt.req_tgl = ~lr_r.req_tgl;
          lr_nxt.st = LRX_IDLE;
        end
      end
      LRX_DROP: begin
        if (!lr_r.s_dv) begin
          lr_nxt.st = LRX_IDLE;
        end
      end
      default: lr_nxt.st = LRX_IDLE;
    endcase
  end

  always_ff @(posedge phy_clk or posedge link_rst) begin
    if (link_rst) begin
      lr_r <= '0;
    end else begin
      lr_r <= lr_nxt;
    end
  end

  // Client receive side, one byte per three clocks at most.
  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.req_s1 = lr_r.req_tgl;
    cr_nxt.req_s2 = cr_r.req_s1;
    unique case (cr_r.st)
      CRX_IDLE: begin
        if (mgr_pending(cr_r.req_s2, cr_r.ack_tgl)) begin
          cr_nxt.len = lr_r.len;
          cr_nxt.err = lr_r.err;
          cr_nxt.addr = '0;
          cr_nxt.st = CRX_ADDR;
        end
      end
      CRX_ADDR: cr_nxt.st = CRX_READ;
      CRX_READ: begin
        cr_nxt.valid = 1'b1;
        cr_nxt.beat.byte_data = rx_rd;
        cr_nxt.beat.start_of_packet = (cr_r.addr == '0);
        cr_nxt.beat.end_of_packet = (cr_r.addr + 1'b1 == cr_r.len);
        cr_nxt.beat.rx_error = '0;
        // R06: error bit zero at end
        cr_nxt.beat.rx_error[`MGR_ERR_PHY] = cr_nxt.beat.end_of_packet &
          cr_r.err;
        cr_nxt.st = CRX_SHOW;
      end
      CRX_SHOW: begin
        if (client_rx_ready) begin
          cr_nxt.valid = 1'b0;
          if (cr_r.beat.end_of_packet) begin
            cr_nxt.ack_tgl = ~cr_r.ack_tgl;
            cr_nxt.st = CRX_IDLE;
          end else begin
            cr_nxt.addr = cr_r.addr + 1'b1;
            cr_nxt.st = CRX_ADDR;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cr_r <= '0;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  assign client_rx_valid = cr_r.valid;
  assign client_rx_beat = cr_r.beat;

  // Length of each enable run, read only by the checks below.
  always_ff @(posedge phy_clk or posedge link_rst) begin
    if (link_rst) begin
      en_run_r <= '0;
    end else begin
      en_run_r <= gmii_transmit_enable ? en_run_r + 1'b1 : '0;
    end
  end

  sequence last_err_byte_s;
    gmii_transmit_error && gmii_transmit_enable ##1 !gmii_transmit_enable;
  endsequence

  tx_frame_len_a: assert property ( // R02
    @(posedge phy_clk) disable iff (link_rst)
    $fell(gmii_transmit_enable) |-> en_run_r == lt_r.len)
    else $error("enable run differs from frame length");
  tx_idle_low_a: assert property ( // R02
    @(posedge phy_clk) disable iff (link_rst)
    lt_r.st == LTX_IDLE && $past(lt_r.st) == LTX_IDLE
      |-> !gmii_transmit_enable)
    else $error("transmit enable high between frames");
  tx_err_mark_a: assert property ( // R03
    @(posedge phy_clk) disable iff (link_rst)
    lt_r.st == LTX_SEND && lt_r.err && lt_r.cnt == lt_r.len - 1'b1
      |=> last_err_byte_s)
    else $error("errored frame sent without transmit error");
  tx_err_clean_a: assert property ( // R03
    @(posedge phy_clk) disable iff (link_rst)
    gmii_transmit_error |-> gmii_transmit_enable && lt_r.err)
    else $error("transmit error on a clean frame");
  rgmii_tx_fall_a: assert property ( // R08
    @(posedge phy_clk) disable iff (link_rst)
    $past(!link_rst) |-> fall_r.tx_nib == lt_r.tx_byte[7:4] &&
      fall_r.tx_ctl == (lt_r.en ^ lt_r.tx_err))
    else $error("falling half does not match byte");
  rgmii_rx_pair_a: assert property ( // R10
    @(posedge phy_clk) disable iff (link_rst)
    lt_r.mode_s2 && $past(lt_r.mode_s2, 2)
      |-> lr_r.s_byte[3:0] == $past(rgmii_receive_nibble, 2))
    else $error("receive low nibble not from rising edge");
  rx_err_catch_a: assert property ( // R06
    @(posedge phy_clk) disable iff (link_rst)
    lr_r.st == LRX_RECV && lr_r.s_dv && lr_r.s_er |=> lr_r.err)
    else $error("receive error not recorded");
  rx_err_out_a: assert property ( // R06
    @(posedge clk) disable iff (reset)
    client_rx_valid |-> client_rx_beat.rx_error[`MGR_ERR_PHY] ==
      (client_rx_beat.end_of_packet && cr_r.err))
    else $error("receive error bit wrong");
  rx_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    client_rx_valid && !client_rx_ready
      |=> client_rx_valid && $stable(client_rx_beat))
    else $error("receive beat changed while stalled");
endmodule

// *** tb/mgr_phy_model.sv ***
// Purpose: PHY stand-in that sends frames into the GMII and RGMII inputs.
// Assumes: phy_clk runs free; data is set a quarter period before each edge.
// Notes: idle data lines invert every cycle so stale bytes never look valid.
`timescale 1ns/1ps
module mgr_phy_model
  import mgr_pkg::*;
(
  input wire logic phy_clk,
  output logic [7:0] gmii_receive_byte,
  output logic gmii_receive_valid,
  output logic gmii_receive_error,
  output logic [3:0] rgmii_receive_nibble,
  output logic rgmii_receive_control
);
  logic busy;
  initial begin
    busy = 1'b0;
    gmii_receive_byte = 8'h5a;
    gmii_receive_valid = 1'b0;
    gmii_receive_error = 1'b0;
    rgmii_receive_nibble = 4'h5;
    rgmii_receive_control = 1'b0;
  end
  always @(negedge phy_clk) begin
    #16;
    if (!busy) begin
      gmii_receive_byte = ~gmii_receive_byte;
      gmii_receive_valid = 1'b0;
      gmii_receive_error = 1'b0;
      rgmii_receive_nibble = ~rgmii_receive_nibble;
      rgmii_receive_control = 1'b0;
    end
  end
  task automatic send_frame(input int n, input logic [7:0] base,
                            input logic bad, input logic rg);
    logic [7:0] b;
    logic e;
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      b = base + 8'(i);
      e = bad && (i == 1);
      @(negedge phy_clk);
      #16;
      // valid span and low nibble first
      gmii_receive_byte = rg ? ~gmii_receive_byte : b;
      gmii_receive_valid = !rg;
      gmii_receive_error = !rg && e;
      rgmii_receive_nibble = rg ? b[3:0] : ~rgmii_receive_nibble;
      rgmii_receive_control = rg;
      @(posedge phy_clk);
      #16;
      // high nibble and error on falling edge
      if (rg) begin
        rgmii_receive_nibble = b[7:4];
        rgmii_receive_control = 1'b1 ^ e;
      end
    end
    @(negedge phy_clk);
    #16;
    gmii_receive_byte = ~gmii_receive_byte;
    gmii_receive_valid = 1'b0;
    gmii_receive_error = 1'b0;
    rgmii_receive_nibble = ~rgmii_receive_nibble;
    rgmii_receive_control = 1'b0;
    @(posedge phy_clk);
    busy = 1'b0;
  endtask
endmodule

// *** tb/test_mgr_frame_port.sv ***
// Purpose: self-checking bench for the GMII/RGMII frame port.
// Assumes: inputs other than the PHY model's change at the falling clk edge; phy_clk is free running.
// Notes: link outputs are watched an eighth of a period after each phy_clk edge.
`timescale 1ns/1ps
`include "mgr_consts.svh"
module test_mgr_frame_port
  import mgr_pkg::*;
;
  logic clk = 1'b0;
  logic phy_clk = 1'b0;
  logic reset = 1'b1;
  logic rgmii_mode = 1'b0;
  logic client_tx_valid = 1'b0;
  logic client_tx_ready;
  mgr_tx_beat_t client_tx_beat = '0;
  logic client_rx_valid;
  logic client_rx_ready = 1'b0;
  mgr_rx_beat_t client_rx_beat;
  logic [7:0] gmii_transmit_byte, gmii_receive_byte, hi_byte;
  logic gmii_transmit_enable, gmii_transmit_error, hi_en, hi_err, err_seen;
  logic gmii_receive_valid, gmii_receive_error, rgmii_transmit_control;
  logic [3:0] rgmii_transmit_nibble, rgmii_receive_nibble;
  logic rgmii_receive_control;
  int n_mismatch = 0, cmp_count = 0, run = 0, frames = 0, cyc = 0;
  logic [7:0] exp_q[$];
  int len_q[$];
  logic errq[$];
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #32 phy_clk = ~phy_clk;
  end
  mgr_frame_port uut (.clk(clk), .reset(reset), .phy_clk(phy_clk),
    .rgmii_mode(rgmii_mode), .client_tx_valid(client_tx_valid),
    .client_tx_ready(client_tx_ready), .client_tx_beat(client_tx_beat),
    .client_rx_valid(client_rx_valid), .client_rx_ready(client_rx_ready),
    .client_rx_beat(client_rx_beat), .gmii_transmit_byte(gmii_transmit_byte),
    .gmii_transmit_enable(gmii_transmit_enable),
    .gmii_transmit_error(gmii_transmit_error),
    .gmii_receive_byte(gmii_receive_byte),
    .gmii_receive_valid(gmii_receive_valid),
    .gmii_receive_error(gmii_receive_error),
    .rgmii_transmit_nibble(rgmii_transmit_nibble),
    .rgmii_transmit_control(rgmii_transmit_control),
    .rgmii_receive_nibble(rgmii_receive_nibble),
    .rgmii_receive_control(rgmii_receive_control));
  mgr_phy_model phy (.phy_clk(phy_clk),
    .gmii_receive_byte(gmii_receive_byte),
    .gmii_receive_valid(gmii_receive_valid),
    .gmii_receive_error(gmii_receive_error),
    .rgmii_receive_nibble(rgmii_receive_nibble),
    .rgmii_receive_control(rgmii_receive_control));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Rising phase: GMII byte and RGMII low nibble with plain enable.
  always @(posedge phy_clk) begin
    #8;
    hi_byte = gmii_transmit_byte;
    hi_en = gmii_transmit_enable;
    hi_err = gmii_transmit_error;
    chk(rgmii_transmit_nibble === hi_byte[3:0] &&
        rgmii_transmit_control === hi_en, "rgmii rise phase");
    if (hi_en === 1'b1) begin
      chk(exp_q.size() > 0 && exp_q[0] === hi_byte, "tx byte");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
      run++;
      err_seen = err_seen | hi_err;
    end else if (run > 0) begin
      chk(len_q.size() > 0 && len_q[0] == run, "tx length");
      chk(errq.size() > 0 && errq[0] === err_seen, "tx error");
      if (len_q.size() > 0) void'(len_q.pop_front());
      if (errq.size() > 0) void'(errq.pop_front());
      run = 0;
      frames++;
    end
    if (run == 0) err_seen = 1'b0;
  end
  // Falling phase: high nibble and enable combined with error.
  always @(negedge phy_clk) begin
    #8;
    chk(gmii_transmit_byte === hi_byte, "gmii held in low phase");
    chk(rgmii_transmit_nibble === hi_byte[7:4] &&
        rgmii_transmit_control === (hi_en ^ hi_err), "rgmii fall");
  end
  task automatic send_tx(input int n, input logic [7:0] base,
                         input logic bad);
    int w;
    for (int i = 0; i < n; i++) begin
      client_tx_valid = 1'b1;
      client_tx_beat.byte_data = base + 8'(i);
      client_tx_beat.start_of_packet = (i == 0);
      client_tx_beat.client_transmit_end_of_packet = (i == n - 1);
      client_tx_beat.client_transmit_error = bad && (i == n - 1);
      exp_q.push_back(base + 8'(i));
      w = 0;
      while (client_tx_ready !== 1'b1 && w < 500) begin
        @(negedge clk);
        w++;
      end
      chk(w < 500, "tx ready never rose");
      @(negedge clk);
    end
    // One clock passes with valid low, so a following call never raises
    // valid in the same time step in which this one lowers it.
    client_tx_valid = 1'b0;
    len_q.push_back(n);
    errq.push_back(bad);
    @(negedge clk);
  endtask
  task automatic read_rx(input int n, input logic [7:0] base,
                         input logic bad);
    int w;
    for (int i = 0; i < n; i++) begin
      w = 0;
      while (client_rx_valid !== 1'b1 && w < 2000) begin
        @(negedge clk);
        w++;
      end
      if (i == 0) begin
        client_rx_ready = 1'b0;
        repeat (4) @(negedge clk);
        chk(client_rx_valid === 1'b1, "rx valid not held");
        client_rx_ready = 1'b1;
      end
      chk(w < 2000 && client_rx_beat.byte_data === base + 8'(i) &&
          client_rx_beat.start_of_packet === (i == 0) &&
          client_rx_beat.end_of_packet === (i == n - 1), "rx beat");
      if (i == n - 1)
        chk(client_rx_beat.rx_error[`MGR_ERR_PHY] === bad, "rx err");
      @(negedge clk);
    end
    // The link side drops a frame that starts before the last acceptance
    // has crossed back, so leave time for that acknowledge to settle.
    repeat (8) @(negedge clk);
  endtask
  task automatic t_reset();
    repeat (10) @(negedge clk);
    // The transmit store resets into its filling state, so ready is high
    // already; nothing is taken until reset is released.
    chk(client_tx_ready === 1'b1 && gmii_transmit_enable === 1'b0 &&
        client_rx_valid === 1'b0, "outputs during reset");
    reset = 1'b0;
    @(negedge clk);
    chk(client_tx_ready === 1'b1, "ready after reset");
  endtask
  task automatic t_tx();
    int w;
    send_tx(5, 8'h10, 1'b0);
    send_tx(3, 8'h20, 1'b1);
    send_tx(1, 8'h30, 1'b1);
    w = 0;
    while (frames < 3 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    chk(frames == 3 && exp_q.size() == 0, "tx frames sent");
  endtask
  task automatic t_rx(input logic rg);
    rgmii_mode = rg;
    repeat (4) @(negedge clk);
    phy.send_frame(4, 8'h40, 1'b0, rg);
    read_rx(4, 8'h40, 1'b0);
    phy.send_frame(3, 8'hf0, 1'b1, rg);
    read_rx(3, 8'hf0, 1'b1);
  endtask
  initial begin
    t_reset();
    t_tx();
    t_rx(1'b0);
    t_rx(1'b1);
    test_done();
  end
endmodule
